// ==== mpgio_defines.vh ====
// Purpose: constants for the multiplexer general-purpose I/O port
// Assumes: 24-bit processor words, X and Y memory spaces at the same addresses
// Notes: offsets are word addresses as seen by the processor
`ifndef MPGIO_DEFINES_VH
`define MPGIO_DEFINES_VH

// register word addresses
`define MPGIO_ADDR_LINES 16'hc082
`define MPGIO_ADDR_INV_ALT 16'hc086
`define MPGIO_ADDR_BUF_CARD 16'he800
`define MPGIO_ADDR_BUF_RACK 16'he802

// line groups inside the 16-bit port word
`define MPGIO_DATA_LSB 0
`define MPGIO_DATA_MSB 7
`define MPGIO_SEL_LSB 8
`define MPGIO_SEL_MSB 15

// buffer direction bits
`define MPGIO_CARD_DATA_BIT 4
`define MPGIO_CARD_SEL_BIT 5
`define MPGIO_RACK_DATA_BIT 0
`define MPGIO_RACK_SEL_BIT 1

// reset values
`define MPGIO_RST_DIR 16'hff00
`define MPGIO_RST_OUTVAL 16'h0000
`define MPGIO_RST_INV 16'h0000
`define MPGIO_RST_ALT 16'h0000
`define MPGIO_RST_BUF_CARD 24'h00_0020
`define MPGIO_RST_BUF_RACK 24'h00_0002

// accessory cycle timing
`define MPGIO_CLK_PERIOD_NS 10
`define MPGIO_SETTLE_NS 1000

// accessory cycle formats
`define MPGIO_FMT_BINARY 2'h0
`define MPGIO_FMT_DISPLAY 2'h1
`define MPGIO_FMT_RESOLVER 2'h2
`define MPGIO_FMT_SERIAL 2'h3

`endif

// ==== mpgio_port.v ====
// Purpose: 16-line multiplexer I/O port with direction, inversion and alternate-use control
// Assumes: one clock, synchronous active-low reset, processor strobes on the same clock
// Notes: pins are split into level in, driven value and output enable
`timescale 1ns/1ps
`include "mpgio_defines.vh"

module mpgio_port
(
	input wire clk_sys_in,
	input wire rstn_in,
	input wire ce_in,
	input wire [15:0] cpu_addr_in,
	input wire cpu_xspace_in,
	input wire cpu_wr_in,
	input wire cpu_rd_in,
	input wire [23:0] cpu_wdata_in,
	output reg [23:0] cpu_rdata_out,
	output reg cpu_rvalid_out,
	input wire rack_variant_in,
	input wire [15:0] line_in,
	output reg [15:0] line_out,
	output reg [15:0] line_oe_out,
	output reg buf_dir_data_out,
	output reg buf_dir_sel_out,
	input wire [15:0] alt_drive_in,
	output reg [15:0] alt_level_out,
	input wire mux_req_in,
	input wire mux_write_in,
	input wire [1:0] mux_format_in,
	input wire [6:0] mux_addr_in,
	input wire [7:0] mux_wdata_in,
	output reg [7:0] mux_rdata_out,
	output reg mux_done_out,
	output reg mux_busy_out
);

	// rounded up so a slow accessory always gets the full settle time
	localparam integer SETTLE_INT = (`MPGIO_SETTLE_NS + `MPGIO_CLK_PERIOD_NS - 1) / `MPGIO_CLK_PERIOD_NS;
	localparam [6:0] SETTLE_CYC = SETTLE_INT[6:0];

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_DATA = 3'h2;
	localparam [2:0] ST_STROBE = 3'h3;
	localparam [2:0] ST_DONE = 3'h4;

	// software-visible state
	reg [15:0] dir_reg;
	reg [15:0] outval_reg;
	reg [15:0] inv_reg;
	reg [15:0] alt_reg;
	reg [23:0] buf_card_reg;
	reg [23:0] buf_rack_reg;

	// pin and strap synchronisers
	reg [15:0] line_meta_reg;
	reg [15:0] line_sync_reg;
	reg rack_meta_reg;
	reg rack_sync_reg;

	// accessory engine
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [6:0] wait_reg;
	reg [6:0] wait_next;
	reg [7:0] eng_sel_reg;
	reg [7:0] eng_sel_next;
	reg [7:0] eng_data_reg;
	reg [7:0] eng_data_next;
	reg eng_write_reg;
	reg eng_write_next;

	wire addr_lines;
	wire addr_inv_alt;
	wire addr_card;
	wire addr_rack;
	wire eng_busy;
	wire [15:0] gp_value;
	wire [15:0] pin_value;
	wire [15:0] line_next;
	wire [15:0] read_lines;
	wire [15:0] dir_wr_value;
	reg [23:0] rdata_next;

	assign addr_lines = (cpu_addr_in == `MPGIO_ADDR_LINES);
	assign addr_inv_alt = (cpu_addr_in == `MPGIO_ADDR_INV_ALT);
	assign addr_card = (cpu_addr_in == `MPGIO_ADDR_BUF_CARD) && !cpu_xspace_in;
	assign addr_rack = (cpu_addr_in == `MPGIO_ADDR_BUF_RACK) && !cpu_xspace_in;
	assign eng_busy = (state_reg != ST_IDLE);

	// the engine owns the select byte while it runs; software values stay untouched
	assign gp_value = {eng_busy ? eng_sel_reg : outval_reg[`MPGIO_SEL_MSB:`MPGIO_SEL_LSB],
		outval_reg[`MPGIO_DATA_MSB:`MPGIO_DATA_LSB]};
	assign pin_value = gp_value ^ inv_reg;
	assign line_next = (alt_reg & alt_drive_in) | (~alt_reg & pin_value);

	// inputs report the pin level after inversion, outputs report the value before inversion and alternate use
	assign read_lines = ((line_sync_reg ^ inv_reg) & ~dir_reg) | (gp_value & dir_reg);

	// no byte-split check in hardware: per-line direction is honoured as written
	assign dir_wr_value = cpu_wdata_in[15:0];

	always @*
	begin
		rdata_next = 24'h00_0000;
		if (addr_lines && cpu_xspace_in)
		begin
			rdata_next = {8'h00, dir_reg};
		end
		else if (addr_lines)
		begin
			rdata_next = {8'h00, read_lines};
		end
		else if (addr_inv_alt && cpu_xspace_in)
		begin
			rdata_next = {8'h00, inv_reg};
		end
		else if (addr_inv_alt)
		begin
			rdata_next = {8'h00, alt_reg};
		end
		else if (addr_card)
		begin
			rdata_next = buf_card_reg;
		end
		else if (addr_rack)
		begin
			rdata_next = buf_rack_reg;
		end
	end

	// accessory cycle: present address, settle, sample or strobe, report
	always @*
	begin
		state_next = state_reg;
		wait_next = wait_reg;
		eng_sel_next = eng_sel_reg;
		eng_data_next = eng_data_reg;
		eng_write_next = eng_write_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (mux_req_in)
				begin
					// serial format keeps the strobe bit high from the start of the cycle
					eng_sel_next = {mux_format_in == `MPGIO_FMT_SERIAL, mux_addr_in};
					eng_data_next = mux_wdata_in;
					eng_write_next = mux_write_in;
					wait_next = SETTLE_CYC;
					state_next = ST_ADDR;
				end
			end
			ST_ADDR:
			begin
				if (wait_reg == 7'h01)
				begin
					state_next = eng_write_reg ? ST_STROBE : ST_DATA;
					wait_next = SETTLE_CYC;
					if (eng_write_reg)
					begin
						eng_sel_next = eng_data_reg;
					end
				end
				else
				begin
					wait_next = wait_reg - 7'h01;
				end
			end
			ST_DATA:
			begin
				// data byte is sampled once, after the full settle time
				eng_data_next = line_sync_reg[`MPGIO_DATA_MSB:`MPGIO_DATA_LSB] ^
					inv_reg[`MPGIO_DATA_MSB:`MPGIO_DATA_LSB];
				state_next = ST_DONE;
			end
			ST_STROBE:
			begin
				if (wait_reg == 7'h01)
				begin
					// select byte returns low so the accessory sees the strobe end
					eng_sel_next = 8'h00;
					state_next = ST_DONE;
				end
				else
				begin
					wait_next = wait_reg - 7'h01;
				end
			end
			ST_DONE:
			begin
				state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			line_meta_reg <= 16'h0000;
			line_sync_reg <= 16'h0000;
			rack_meta_reg <= 1'b0;
			rack_sync_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			line_meta_reg <= line_in;
			line_sync_reg <= line_meta_reg;
			rack_meta_reg <= rack_variant_in;
			rack_sync_reg <= rack_meta_reg;
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			dir_reg <= `MPGIO_RST_DIR;
			outval_reg <= `MPGIO_RST_OUTVAL;
			inv_reg <= `MPGIO_RST_INV;
			alt_reg <= `MPGIO_RST_ALT;
			buf_card_reg <= `MPGIO_RST_BUF_CARD;
			buf_rack_reg <= `MPGIO_RST_BUF_RACK;
		end
		else if (ce_in && cpu_wr_in)
		begin
			if (addr_lines && cpu_xspace_in)
			begin
				dir_reg <= dir_wr_value;
			end
			else if (addr_lines)
			begin
				// input lines keep their stored value so a later turn-around starts clean
				outval_reg <= (cpu_wdata_in[15:0] & dir_reg) | (outval_reg & ~dir_reg);
			end
			else if (addr_inv_alt && cpu_xspace_in)
			begin
				inv_reg <= cpu_wdata_in[15:0];
			end
			else if (addr_inv_alt)
			begin
				alt_reg <= cpu_wdata_in[15:0];
			end
			// buffer words keep all 24 bits; only the steering bits reach the pins
			else if (addr_card)
			begin
				buf_card_reg <= cpu_wdata_in;
			end
			else if (addr_rack)
			begin
				buf_rack_reg <= cpu_wdata_in;
			end
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			state_reg <= ST_IDLE;
			wait_reg <= 7'h00;
			eng_sel_reg <= 8'h00;
			eng_data_reg <= 8'h00;
			eng_write_reg <= 1'b0;
			mux_rdata_out <= 8'h00;
			mux_done_out <= 1'b0;
			mux_busy_out <= 1'b0;
		end
		else if (ce_in)
		begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			eng_sel_reg <= eng_sel_next;
			eng_data_reg <= eng_data_next;
			eng_write_reg <= eng_write_next;
			mux_busy_out <= (state_next != ST_IDLE);
			mux_done_out <= (state_reg == ST_DONE);
			if (state_reg == ST_DONE && !eng_write_reg)
			begin
				mux_rdata_out <= eng_data_reg;
			end
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (!rstn_in)
		begin
			cpu_rdata_out <= 24'h00_0000;
			cpu_rvalid_out <= 1'b0;
			line_out <= `MPGIO_RST_OUTVAL;
			line_oe_out <= `MPGIO_RST_DIR;
			buf_dir_data_out <= 1'b0;
			buf_dir_sel_out <= 1'b1;
			alt_level_out <= 16'h0000;
		end
		else if (ce_in)
		begin
			cpu_rvalid_out <= cpu_rd_in;
			if (cpu_rd_in)
			begin
				cpu_rdata_out <= rdata_next;
			end
			line_out <= line_next;
			// a mismatch with the buffer direction is left for software to avoid
			line_oe_out <= dir_reg;
			alt_level_out <= line_sync_reg;
			// the strap picks which buffer word steers the transceivers
			if (rack_sync_reg)
			begin
				buf_dir_data_out <= buf_rack_reg[`MPGIO_RACK_DATA_BIT];
				buf_dir_sel_out <= buf_rack_reg[`MPGIO_RACK_SEL_BIT];
			end
			else
			begin
				buf_dir_data_out <= buf_card_reg[`MPGIO_CARD_DATA_BIT];
				buf_dir_sel_out <= buf_card_reg[`MPGIO_CARD_SEL_BIT];
			end
		end
	end

endmodule

// ==== mpgio_props.sv ====
// Purpose: port checks for the multiplexer I/O port
// Assumes: ce_in stays high while an accessory cycle runs
// Notes: bound to every port instance
`timescale 1ns/1ps
module mpgio_props
(
	input wire clk_sys_in,
	input wire rstn_in,
	input wire ce_in,
	input wire cpu_rd_in,
	input wire cpu_rvalid_out,
	input wire [15:0] line_out,
	input wire [15:0] line_oe_out,
	input wire buf_dir_data_out,
	input wire buf_dir_sel_out,
	input wire mux_req_in,
	input wire mux_write_in,
	input wire mux_done_out,
	input wire mux_busy_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	wire take = ce_in && mux_req_in && !mux_busy_out;
	a_read_answered: assert property (ce_in && cpu_rd_in |=> cpu_rvalid_out)
		else $error("read not answered");
	a_rvalid_has_cause: assert property (cpu_rvalid_out |-> $past(cpu_rd_in))
		else $error("read answer without read");
	a_reset_lines: assert property ($rose(rstn_in) |-> line_oe_out == 16'hff00 && line_out == 16'h0000)
		else $error("lines wrong after reset");
	a_reset_buffers: assert property ($rose(rstn_in) |-> buf_dir_sel_out && !buf_dir_data_out)
		else $error("buffer direction wrong after reset");
	a_busy_after_take: assert property (take |=> mux_busy_out)
		else $error("accessory cycle not started");
	a_read_cycle_length: assert property (take && !mux_write_in |-> ##103 mux_done_out)
		else $error("accessory read length wrong");
	a_write_cycle_length: assert property (take && mux_write_in |-> ##202 mux_done_out)
		else $error("accessory write length wrong");
	a_done_ends_busy: assert property (mux_done_out |-> !mux_busy_out && $past(mux_busy_out))
		else $error("done without busy end");
	a_engine_keeps_dir: assert property (mux_busy_out |-> $stable(line_oe_out))
		else $error("direction moved in accessory cycle");
endmodule
bind mpgio_port mpgio_props u_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
	.cpu_rd_in(cpu_rd_in), .cpu_rvalid_out(cpu_rvalid_out), .line_out(line_out), .line_oe_out(line_oe_out),
	.buf_dir_data_out(buf_dir_data_out), .buf_dir_sel_out(buf_dir_sel_out), .mux_req_in(mux_req_in),
	.mux_write_in(mux_write_in), .mux_done_out(mux_done_out), .mux_busy_out(mux_busy_out));

// ==== mpgio_lines_model.sv ====
// Purpose: external side of the sixteen port lines
// Assumes: each line has a pull-up, an accessory may drive input lines
// Notes: never drives a line that the port drives
`timescale 1ns/1ps
module mpgio_lines_model
(
	input wire [15:0] line_out,
	input wire [15:0] line_oe_out,
	input wire [15:0] ext_en_in,
	input wire [15:0] ext_val_in,
	output wire [15:0] pin_out
);
	// a released line floats high, so a stale value can never pass for input
	assign pin_out = (line_oe_out & line_out) | (~line_oe_out & ((ext_en_in & ext_val_in) | ~ext_en_in));
endmodule

// ==== mux_port_general_io_bench.sv ====
// Purpose: self-checking bench of the multiplexer I/O port
// Assumes: line model closes the pin loop
// Notes: random values come from a fixed-seed shift register
`timescale 1ns/1ps
module mux_port_general_io_bench;
	logic clk_sys_in = 0, rstn_in = 0, ce_in = 1, cpu_xspace_in = 0, cpu_wr_in = 0, cpu_rd_in = 0;
	logic rack_variant_in = 0, mux_req_in = 0, mux_write_in = 0;
	logic [15:0] cpu_addr_in = 16'h0000, alt_drive_in = 16'h0000, ext_en = 16'h0000, ext_val = 16'h0000;
	logic [15:0] seed = 16'h9483, inv, r;
	logic [23:0] cpu_wdata_in = 24'h00_0000;
	logic [1:0] mux_format_in = 2'h0;
	logic [6:0] mux_addr_in = 7'h00;
	logic [7:0] mux_wdata_in = 8'h00;
	wire [15:0] pins, line_out, line_oe_out, alt_level_out;
	wire [23:0] cpu_rdata_out;
	wire [7:0] mux_rdata_out;
	wire cpu_rvalid_out, buf_dir_data_out, buf_dir_sel_out, mux_done_out, mux_busy_out;
	integer num_errors = 0, check_count = 0, i, j;
	mpgio_port DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in), .cpu_addr_in(cpu_addr_in),
		.cpu_xspace_in(cpu_xspace_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in), .cpu_wdata_in(cpu_wdata_in),
		.cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(cpu_rvalid_out), .rack_variant_in(rack_variant_in),
		.line_in(pins), .line_out(line_out), .line_oe_out(line_oe_out), .buf_dir_data_out(buf_dir_data_out),
		.buf_dir_sel_out(buf_dir_sel_out), .alt_drive_in(alt_drive_in), .alt_level_out(alt_level_out),
		.mux_req_in(mux_req_in), .mux_write_in(mux_write_in), .mux_format_in(mux_format_in),
		.mux_addr_in(mux_addr_in), .mux_wdata_in(mux_wdata_in), .mux_rdata_out(mux_rdata_out),
		.mux_done_out(mux_done_out), .mux_busy_out(mux_busy_out));
	mpgio_lines_model u_lines (.line_out(line_out), .line_oe_out(line_oe_out), .ext_en_in(ext_en),
		.ext_val_in(ext_val), .pin_out(pins));
	initial
	begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	function automatic [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic [15:0] drive(input [15:0] v, input [15:0] n, input [15:0] a, input [15:0] s);
		drive = (a & s) | ((v ^ n) & ~s);
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input [23:0] got, input [23:0] e);
		check_count = check_count + 1;
		if (got !== e)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	task wr(input x, input [15:0] a, input [23:0] d);
		@(negedge clk_sys_in);
		cpu_xspace_in = x;
		cpu_addr_in = a;
		cpu_wdata_in = d;
		cpu_wr_in = 1;
		@(negedge clk_sys_in);
		cpu_wr_in = 0;
	endtask
	task rd(input x, input [15:0] a, input [23:0] e);
		@(negedge clk_sys_in);
		cpu_xspace_in = x;
		cpu_addr_in = a;
		cpu_rd_in = 1;
		@(negedge clk_sys_in);
		cpu_rd_in = 0;
		chk(cpu_rdata_out, e);
	endtask
	task reset_check;
		rd(1, 16'hc082, 24'h00_ff00);
		rd(0, 16'hc082, 24'h00_00ff);
		rd(1, 16'hc086, 24'h00_0000);
		rd(0, 16'hc086, 24'h00_0000);
		rd(0, 16'he800, 24'h00_0020);
		rd(0, 16'he802, 24'h00_0002);
		rd(0, 16'hc084, 24'h00_0000);
		chk(pins[15:8], 8'h00);
		$display("test reset finished");
	endtask
	task engine(input w, input [1:0] f);
		seed = lfsr(seed);
		ext_val = {8'h00, seed[7:0]};
		@(negedge clk_sys_in);
		mux_write_in = w;
		mux_format_in = f;
		mux_addr_in = seed[14:8];
		mux_wdata_in = ~seed[7:0];
		mux_req_in = 1;
		@(negedge clk_sys_in);
		mux_req_in = 0;
		repeat (50) @(negedge clk_sys_in);
		chk(line_out[15:8], {f == 2'h3, mux_addr_in});
		// a request while busy must be dropped
		mux_req_in = 1;
		@(negedge clk_sys_in);
		mux_req_in = 0;
		if (w)
		begin
			repeat (100) @(negedge clk_sys_in);
			chk(line_out[15:8], mux_wdata_in);
		end
		for (i = 0; i < 300 && mux_done_out !== 1'b1; i = i + 1)
			@(negedge clk_sys_in);
		if (i == 300)
		begin
			num_errors = num_errors + 1;
			report_and_stop;
		end
		else if (!w)
			chk(mux_rdata_out, ext_val[7:0]);
	endtask
	initial
	begin
		repeat (16) @(negedge clk_sys_in);
		rstn_in = 1;
		reset_check;
		ext_en = 16'h00ff;
		// accessory cycles run with every line non-inverting and the reset directions
		for (j = 0; j < 8; j = j + 1)
			engine(j[0], j[2:1]);
		$display("test engine finished");
		seed = lfsr(seed);
		ext_val = seed;
		repeat (3) @(negedge clk_sys_in);
		rd(0, 16'hc082, {16'h0000, seed[7:0]});
		chk(alt_level_out, {8'h00, seed[7:0]});
		seed = lfsr(seed);
		inv = seed;
		wr(1, 16'hc086, {8'h00, inv});
		repeat (3) @(negedge clk_sys_in);
		rd(0, 16'hc082, {16'h0000, ext_val[7:0] ^ inv[7:0]});
		chk(pins, {inv[15:8], ext_val[7:0]});
		$display("test inversion finished");
		wr(1, 16'hc082, 24'h00_00ff);
		wr(0, 16'he800, 24'h00_0010);
		ext_en = 16'h0000;
		seed = lfsr(seed);
		wr(0, 16'hc082, {8'h00, seed});
		repeat (3) @(negedge clk_sys_in);
		r = drive(seed, inv, 16'h0000, 16'h0000);
		chk(pins, {8'hff, r[7:0]});
		rd(0, 16'hc082, {8'h00, ~inv[15:8], seed[7:0]});
		chk({buf_dir_sel_out, buf_dir_data_out}, 2'b01);
		rack_variant_in = 1;
		repeat (4) @(negedge clk_sys_in);
		chk({buf_dir_sel_out, buf_dir_data_out}, 2'b10);
		wr(0, 16'he802, 24'h00_0001);
		repeat (2) @(negedge clk_sys_in);
		chk({buf_dir_sel_out, buf_dir_data_out}, 2'b01);
		$display("test direction finished");
		alt_drive_in = lfsr(seed);
		wr(0, 16'hc086, 24'h00_0f0f);
		repeat (3) @(negedge clk_sys_in);
		r = drive(seed, inv, alt_drive_in, 16'h0f0f);
		chk(pins[7:0], r[7:0]);
		ce_in = 0;
		wr(1, 16'hc086, 24'h00_0000);
		ce_in = 1;
		rd(1, 16'hc086, {8'h00, inv});
		$display("test alternate finished");
		rstn_in = 0;
		repeat (2) @(negedge clk_sys_in);
		rstn_in = 1;
		reset_check;
		report_and_stop;
	end
endmodule
